// file: verilog/filter_cal_pkg.sv
/*
 * Shared constants for the filter calibration control block: register
 * offsets, field positions, reset values, frame layout, timing figures
 * and the state encodings of both sequencers.
 * Assumes a single 200 MHz reference clock drives all logic.
 */
package filter_cal_pkg;

	// clocking and timing figures
	localparam int REF_CLK_MHZ = 200;
	localparam int POR_TIME_US = 250;
	localparam int POR_CYCLES = POR_TIME_US * REF_CLK_MHZ;
	localparam int OTP_PULSE_NS = 2000;
	localparam int OTP_PULSE_CYCLES = OTP_PULSE_NS * REF_CLK_MHZ / 1000;
	localparam int CAL_TIMEOUT_US = 1000;
	localparam int CAL_TIMEOUT_CYCLES = CAL_TIMEOUT_US * REF_CLK_MHZ;

	// serial frame layout, most significant field first
	localparam int FRAME_BITS = 32;
	localparam int DATA_BITS = 24;
	localparam int ADDR_BITS = 5;
	localparam int CHIP_BITS = 3;

	// register offsets
	localparam logic [4:0] REG_READ_POINTER = 5'h00;
	localparam logic [4:0] REG_CAL_CONTROL = 5'h01;
	localparam logic [4:0] REG_COARSE_BW = 5'h02;
	localparam logic [4:0] REG_FINE_BW = 5'h03;
	localparam logic [4:0] REG_CAL_START = 5'h04;
	localparam logic [4:0] REG_CAL_PERIOD = 5'h05;
	localparam logic [4:0] REG_MEAS_ADJUST = 5'h06;
	localparam logic [4:0] REG_STATUS = 5'h08;
	localparam logic [4:0] REG_OTP_MODE = 5'h0b;
	localparam logic [4:0] REG_OTP_INDEX = 5'h0c;
	localparam logic [4:0] REG_OTP_STROBE = 5'h0d;

	// field positions
	localparam int SOFT_RESET_BIT = 5;
	localparam int CTRL_CAL_ENABLE_BIT = 1;
	localparam int CTRL_DOUBLER_BIT = 2;
	localparam int CTRL_USE_SETTINGS_BIT = 4;
	localparam int COARSE_LSB = 6;
	localparam int STATUS_BUSY_BIT = 4;
	localparam int STATUS_OTP_ACTIVE_BIT = 5;
	localparam int STATUS_OTP_LSB = 6;
	localparam int OTP_USE_STORED_BIT = 13;
	localparam int OTP_FINE_LSB = 0;
	localparam int OTP_COARSE_LSB = 4;
	localparam int OTP_BITS = 16;

	// reset values
	localparam logic [23:0] CAL_CONTROL_RESET = 24'h00_0000;
	localparam logic [3:0] COARSE_RESET = 4'h0;
	localparam logic [3:0] FINE_RESET = 4'h6;
	localparam logic [14:0] CAL_PERIOD_RESET = 15'h0000;
	localparam logic [8:0] MEAS_ADJUST_RESET = 9'h000;

	// fine bandwidth codes and their typical ratios in thousandths
	localparam logic [3:0] FINE_CODE_MAX = 4'hb;
	localparam int FINE_CODES = 12;
	localparam logic [10:0] FINE_RATIO_MILLI [FINE_CODES] = '{
		11'd803, 11'd832, 11'd862, 11'd893, 11'd926, 11'd959,
		11'd994, 11'd1030, 11'd1063, 11'd1097, 11'd1136, 11'd1183};

	// measured time is scaled down by this shift before the adjust
	localparam int CAL_SHIFT = 8;

	typedef enum logic [2:0] {
		CAL_IDLE = 3'b001,
		CAL_MEASURE = 3'b010,
		CAL_RESOLVE = 3'b100
	} cal_state_t;

	typedef enum logic [1:0] {
		OTP_IDLE = 2'b01,
		OTP_PULSE = 2'b10
	} otp_state_t;

endpackage

// file: verilog/rc_cal_sequencer.sv
/*
 * RC calibration sequencer: charges the on-chip RC, adds up elapsed
 * calibration clock time until the RC threshold trips, then turns it
 * into a fine bandwidth code.
 * Assumes edge pulses and the trip level are already synchronised.
 */
`timescale 1ns/1ps
module rc_cal_sequencer #(
	parameter int TIMEOUT_CYCLES = filter_cal_pkg::CAL_TIMEOUT_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clear,
	input wire logic start,
	input wire logic doubler_enable,
	input wire logic [14:0] period_ps,
	input wire logic [8:0] adjust,
	input wire logic cal_rise,
	input wire logic cal_fall,
	input wire logic rc_trip,
	output logic rc_charge,
	output logic busy,
	output logic done,
	output logic [3:0] code
);
	filter_cal_pkg::cal_state_t state;
	logic [31:0] elapsed_ps;
	logic [31:0] timer;
	logic [15:0] step_ps;
	logic step;
	logic [23:0] scaled;
	logic [23:0] trimmed;

	// the doubler counts both edges, each worth half a period
	assign step = cal_rise | (doubler_enable & cal_fall);
	assign step_ps = doubler_enable ? {2'b00, period_ps[14:1]}
		: {1'b0, period_ps};
	assign scaled = elapsed_ps[filter_cal_pkg::CAL_SHIFT +: 24];
	assign trimmed = scaled - {15'h0000, adjust};

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= filter_cal_pkg::CAL_IDLE;
			elapsed_ps <= 32'h0000_0000;
			timer <= 32'h0000_0000;
			code <= filter_cal_pkg::FINE_RESET;
			done <= 1'b0;
		end else if (clear) begin
			state <= filter_cal_pkg::CAL_IDLE;
			elapsed_ps <= 32'h0000_0000;
			timer <= 32'h0000_0000;
			code <= filter_cal_pkg::FINE_RESET;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			case (state)
				filter_cal_pkg::CAL_IDLE: begin
					if (start) begin
						state <= filter_cal_pkg::CAL_MEASURE;
						elapsed_ps <= 32'h0000_0000;
						timer <= 32'h0000_0000;
					end
				end
				filter_cal_pkg::CAL_MEASURE: begin
					timer <= timer + 32'h0000_0001;
					if (step)
						elapsed_ps <= elapsed_ps + {16'h0000, step_ps};
					// a dead calibration clock must not hang the busy flag
					if (rc_trip || timer == 32'(TIMEOUT_CYCLES - 1))
						state <= filter_cal_pkg::CAL_RESOLVE;
				end
				filter_cal_pkg::CAL_RESOLVE: begin
					state <= filter_cal_pkg::CAL_IDLE;
					done <= 1'b1;
					// a short RC needs a lower code; saturate into 0..11
					if (scaled < {15'h0000, adjust})
						code <= 4'h0;
					else if (trimmed > {20'h0_0000, filter_cal_pkg::FINE_CODE_MAX})
						code <= filter_cal_pkg::FINE_CODE_MAX;
					else
						code <= trimmed[3:0];
				end
				default: state <= filter_cal_pkg::CAL_IDLE;
			endcase
		end
	end

	assign busy = (state != filter_cal_pkg::CAL_IDLE);
	assign rc_charge = (state == filter_cal_pkg::CAL_MEASURE);

endmodule

// file: verilog/filter_cal_control.sv
/*
 * Digital control of a programmable low-pass filter: serial slave port,
 * register file, RC calibration sequencer, one-time memory programming
 * and power-on / soft reset.
 * Assumes every input pin is asynchronous to ref_clk; all but rst_b are synchronised here;
 * the serial and calibration clocks must stay well under ref_clk / 2.
 */
`timescale 1ns/1ps
module filter_cal_control #(
	parameter int POR_CYCLES = filter_cal_pkg::POR_CYCLES,
	parameter int CAL_TIMEOUT_CYCLES = filter_cal_pkg::CAL_TIMEOUT_CYCLES,
	parameter int OTP_PULSE_CYCLES = filter_cal_pkg::OTP_PULSE_CYCLES,
	// arbitrary value, not tied to any real part
	parameter logic [2:0] DEVICE_BUS_ADDRESS = 3'h3,
	// arbitrary value, not tied to any real part
	parameter logic [23:0] DEVICE_ID = 24'h00_1234
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic serial_port_select_b,
	input wire logic serial_clock,
	input wire logic serial_data_in,
	output logic serial_data_out,
	output logic serial_data_out_oe,
	input wire logic calibration_clock_pin,
	input wire logic rc_threshold_trip,
	output logic rc_charge_enable,
	output logic clock_doubler_enable,
	output logic use_settings,
	output logic [3:0] coarse_bandwidth_code,
	output logic [3:0] fine_bandwidth_code,
	output logic [11:0] fine_tune_select,
	output logic [10:0] fine_tune_ratio_milli,
	output logic otp_program_pulse,
	output logic [3:0] otp_program_index,
	output logic registers_ready
);
	localparam int N_PINS = 5;

	// two-flop synchronisers; stage one feeds stage two only
	logic [N_PINS-1:0] pin_raw;
	logic [N_PINS-1:0] pin_meta;
	logic [N_PINS-1:0] pin_sync;
	assign pin_raw = {rc_threshold_trip, calibration_clock_pin,
		serial_data_in, serial_clock, serial_port_select_b};
	genvar gi;
	generate
		for (gi = 0; gi < N_PINS; gi++) begin : g_sync
			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					pin_meta[gi] <= 1'b1;
					pin_sync[gi] <= 1'b1;
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
				end
			end
		end
	endgenerate

	logic sel_s, sclk_s, sdi_s, calclk_s, trip_s;
	assign {trip_s, calclk_s, sdi_s, sclk_s, sel_s} = pin_sync;

	logic sel_d, sclk_d, calclk_d;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			sel_d <= 1'b1;
			sclk_d <= 1'b1;
			calclk_d <= 1'b1;
		end else begin
			sel_d <= sel_s;
			sclk_d <= sclk_s;
			calclk_d <= calclk_s;
		end
	end

	logic sel_fall, sel_rise, sclk_rise, cal_rise, cal_fall;
	assign sel_fall = sel_d & ~sel_s;
	assign sel_rise = ~sel_d & sel_s;
	assign sclk_rise = ~sclk_d & sclk_s & ~sel_s;
	assign cal_rise = ~calclk_d & calclk_s;
	assign cal_fall = calclk_d & ~calclk_s;

	// power-on hold: registers stay at defaults until the count ends
	logic [31:0] por_count;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			por_count <= 32'h0000_0000;
			registers_ready <= 1'b0;
		end else if (!registers_ready) begin
			por_count <= por_count + 32'h0000_0001;
			if (por_count == 32'(POR_CYCLES - 1))
				registers_ready <= 1'b1;
		end
	end

	// serial frame engine
	logic [31:0] shift_in;
	logic [31:0] shift_out;
	logic [5:0] bit_count;
	logic [23:0] read_data;
	logic [4:0] read_pointer;
	logic addressed;
	logic commit;
	logic [23:0] wr_data;
	logic [4:0] wr_addr;
	logic [2:0] wr_chip;
	assign wr_data = shift_in[31:8];
	assign wr_addr = shift_in[7:3];
	assign wr_chip = shift_in[2:0];

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			shift_in <= 32'h0000_0000;
			shift_out <= 32'h0000_0000;
			bit_count <= 6'h00;
			serial_data_out <= 1'b0;
		end else if (sel_fall) begin
			// snapshot before any write of this frame can land
			shift_out <= {read_data, read_pointer, DEVICE_BUS_ADDRESS};
			bit_count <= 6'h00;
		end else if (sclk_rise) begin
			shift_in <= {shift_in[30:0], sdi_s};
			serial_data_out <= shift_out[31];
			shift_out <= {shift_out[30:0], 1'b0};
			if (bit_count != 6'h3f)
				bit_count <= bit_count + 6'h01;
		end
	end

	// a short or long frame is dropped entirely
	assign commit = sel_rise && bit_count == 6'(filter_cal_pkg::FRAME_BITS)
		&& wr_chip == DEVICE_BUS_ADDRESS && registers_ready;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			addressed <= 1'b0;
		else if (!registers_ready)
			addressed <= 1'b0;
		else if (sel_rise && bit_count == 6'(filter_cal_pkg::FRAME_BITS))
			addressed <= (wr_chip == DEVICE_BUS_ADDRESS);
	end
	assign serial_data_out_oe = addressed;

	logic wr_pointer, wr_ctrl, wr_coarse, wr_fine, wr_start, wr_period;
	logic wr_adjust, wr_otp_mode, wr_otp_index, wr_otp_strobe;
	assign wr_pointer = commit && wr_addr == filter_cal_pkg::REG_READ_POINTER;
	assign wr_ctrl = commit && wr_addr == filter_cal_pkg::REG_CAL_CONTROL;
	assign wr_coarse = commit && wr_addr == filter_cal_pkg::REG_COARSE_BW;
	assign wr_fine = commit && wr_addr == filter_cal_pkg::REG_FINE_BW;
	assign wr_start = commit && wr_addr == filter_cal_pkg::REG_CAL_START;
	assign wr_period = commit && wr_addr == filter_cal_pkg::REG_CAL_PERIOD;
	assign wr_adjust = commit && wr_addr == filter_cal_pkg::REG_MEAS_ADJUST;
	assign wr_otp_mode = commit && wr_addr == filter_cal_pkg::REG_OTP_MODE;
	assign wr_otp_index = commit && wr_addr == filter_cal_pkg::REG_OTP_INDEX;
	assign wr_otp_strobe = commit
		&& wr_addr == filter_cal_pkg::REG_OTP_STROBE;

	// soft reset: armed by a one, fired by the following zero
	logic soft_armed;
	logic soft_clear;
	logic reg_clear;
	assign soft_clear = wr_pointer && soft_armed
		&& !wr_data[filter_cal_pkg::SOFT_RESET_BIT];
	assign reg_clear = soft_clear || !registers_ready;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			soft_armed <= 1'b0;
			read_pointer <= 5'h00;
		end else if (!registers_ready) begin
			soft_armed <= 1'b0;
			read_pointer <= 5'h00;
		end else if (wr_pointer) begin
			soft_armed <= wr_data[filter_cal_pkg::SOFT_RESET_BIT];
			read_pointer <= soft_clear ? 5'h00 : wr_data[4:0];
		end
	end

	logic [23:0] cal_control;
	logic [3:0] coarse_reg;
	logic [3:0] fine_reg;
	logic [14:0] cal_period;
	logic [8:0] meas_adjust;
	logic otp_mode;
	logic [3:0] otp_index;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			cal_control <= filter_cal_pkg::CAL_CONTROL_RESET;
			coarse_reg <= filter_cal_pkg::COARSE_RESET;
			cal_period <= filter_cal_pkg::CAL_PERIOD_RESET;
			meas_adjust <= filter_cal_pkg::MEAS_ADJUST_RESET;
			otp_mode <= 1'b0;
			otp_index <= 4'h0;
		end else if (reg_clear) begin
			cal_control <= filter_cal_pkg::CAL_CONTROL_RESET;
			coarse_reg <= filter_cal_pkg::COARSE_RESET;
			cal_period <= filter_cal_pkg::CAL_PERIOD_RESET;
			meas_adjust <= filter_cal_pkg::MEAS_ADJUST_RESET;
			otp_mode <= 1'b0;
			otp_index <= 4'h0;
		end else begin
			if (wr_ctrl)
				cal_control <= wr_data;
			if (wr_coarse)
				coarse_reg <= wr_data[filter_cal_pkg::COARSE_LSB +: 4];
			if (wr_period)
				cal_period <= wr_data[14:0];
			if (wr_adjust)
				meas_adjust <= wr_data[8:0];
			if (wr_otp_mode)
				otp_mode <= wr_data[0];
			if (wr_otp_index)
				otp_index <= wr_data[3:0];
		end
	end

	// calibration sequencer
	logic cal_start;
	logic cal_busy;
	logic cal_done;
	logic [3:0] cal_code;
	assign cal_start = wr_start && wr_data == 24'h00_0000
		&& cal_control[filter_cal_pkg::CTRL_CAL_ENABLE_BIT];
	assign clock_doubler_enable =
		cal_control[filter_cal_pkg::CTRL_DOUBLER_BIT];
	assign use_settings = cal_control[filter_cal_pkg::CTRL_USE_SETTINGS_BIT];

	rc_cal_sequencer #(
		.TIMEOUT_CYCLES(CAL_TIMEOUT_CYCLES)
	) u_rc_cal (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.clear(reg_clear),
		.start(cal_start),
		.doubler_enable(clock_doubler_enable),
		.period_ps(cal_period),
		.adjust(meas_adjust),
		.cal_rise(cal_rise),
		.cal_fall(cal_fall),
		.rc_trip(trip_s),
		.rc_charge(rc_charge_enable),
		.busy(cal_busy),
		.done(cal_done),
		.code(cal_code)
	);

	// the result lands over a same-cycle host write to the fine field
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			fine_reg <= filter_cal_pkg::FINE_RESET;
		else if (reg_clear)
			fine_reg <= filter_cal_pkg::FINE_RESET;
		else if (cal_done)
			fine_reg <= cal_code;
		else if (wr_fine)
			fine_reg <= wr_data[3:0];
	end

	// one-time memory: bits can only be set; only rst_b clears them
	logic [filter_cal_pkg::OTP_BITS-1:0] otp_bits;
	filter_cal_pkg::otp_state_t otp_state;
	logic [15:0] otp_timer;
	logic otp_active;
	assign otp_active = (otp_state == filter_cal_pkg::OTP_PULSE);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			otp_state <= filter_cal_pkg::OTP_IDLE;
			otp_timer <= 16'h0000;
			otp_program_index <= 4'h0;
			otp_program_pulse <= 1'b0;
		end else begin
			case (otp_state)
				filter_cal_pkg::OTP_IDLE: begin
					// a strobe while a pulse runs is ignored
					if (wr_otp_strobe && otp_mode) begin
						otp_state <= filter_cal_pkg::OTP_PULSE;
						otp_program_index <= otp_index;
						otp_program_pulse <= 1'b1;
						otp_timer <= 16'h0000;
					end
				end
				filter_cal_pkg::OTP_PULSE: begin
					otp_timer <= otp_timer + 16'h0001;
					if (otp_timer == 16'(OTP_PULSE_CYCLES - 1)) begin
						otp_state <= filter_cal_pkg::OTP_IDLE;
						otp_program_pulse <= 1'b0;
					end
				end
				default: begin
					otp_state <= filter_cal_pkg::OTP_IDLE;
					otp_program_pulse <= 1'b0;
				end
			endcase
		end
	end

	// the array survives soft reset; only the pulse end sets a bit
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			otp_bits <= 16'h0000;
		else if (otp_active && otp_timer == 16'(OTP_PULSE_CYCLES - 1))
			otp_bits[otp_program_index] <= 1'b1;
	end

	// effective codes: stored values only once their flag is burned
	logic use_stored;
	logic [3:0] fine_eff;
	assign use_stored = otp_bits[filter_cal_pkg::OTP_USE_STORED_BIT];
	assign fine_eff = use_stored
		? otp_bits[filter_cal_pkg::OTP_FINE_LSB +: 4] : fine_reg;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			coarse_bandwidth_code <= filter_cal_pkg::COARSE_RESET;
			fine_bandwidth_code <= filter_cal_pkg::FINE_RESET;
		end else begin
			coarse_bandwidth_code <= use_stored
				? otp_bits[filter_cal_pkg::OTP_COARSE_LSB +: 4]
				: coarse_reg;
			// out-of-range codes saturate at the top ratio
			fine_bandwidth_code <= (fine_eff > filter_cal_pkg::FINE_CODE_MAX)
				? filter_cal_pkg::FINE_CODE_MAX : fine_eff;
		end
	end

	generate
		for (gi = 0; gi < filter_cal_pkg::FINE_CODES; gi++) begin : g_fine
			assign fine_tune_select[gi] = (fine_bandwidth_code == 4'(gi));
		end
	endgenerate
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			fine_tune_ratio_milli <= 11'h000;
		else
			fine_tune_ratio_milli <=
				filter_cal_pkg::FINE_RATIO_MILLI[fine_bandwidth_code];
	end

	// read mux; unlisted offsets read as zero
	always_comb begin
		read_data = 24'h00_0000;
		case (read_pointer)
			filter_cal_pkg::REG_READ_POINTER: read_data = DEVICE_ID;
			filter_cal_pkg::REG_CAL_CONTROL: read_data = cal_control;
			filter_cal_pkg::REG_COARSE_BW:
				read_data[filter_cal_pkg::COARSE_LSB +: 4] = coarse_reg;
			filter_cal_pkg::REG_FINE_BW: read_data[3:0] = fine_reg;
			filter_cal_pkg::REG_CAL_PERIOD: read_data[14:0] = cal_period;
			filter_cal_pkg::REG_MEAS_ADJUST: read_data[8:0] = meas_adjust;
			filter_cal_pkg::REG_STATUS: begin
				read_data[3:0] = cal_code;
				read_data[filter_cal_pkg::STATUS_BUSY_BIT] = cal_busy;
				read_data[filter_cal_pkg::STATUS_OTP_ACTIVE_BIT] =
					otp_active;
				read_data[filter_cal_pkg::STATUS_OTP_LSB +: 16] = otp_bits;
			end
			filter_cal_pkg::REG_OTP_MODE: read_data[0] = otp_mode;
			filter_cal_pkg::REG_OTP_INDEX: read_data[3:0] = otp_index;
			default: read_data = 24'h00_0000;
		endcase
	end

endmodule

// file: verification/filter_cal_control_properties.sv
/*
 * Concurrent checks on the top ports of the filter control block.
 * Assumes the bind below hands on the shortened count parameters.
 */
`timescale 1ns/1ps
module filter_cal_control_properties #(
	parameter int POR_CYCLES = 20,
	parameter int CAL_TIMEOUT_CYCLES = 200,
	parameter int OTP_PULSE_CYCLES = 8
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic serial_port_select_b,
	input wire logic serial_clock,
	input wire logic serial_data_out,
	input wire logic serial_data_out_oe,
	input wire logic rc_threshold_trip,
	input wire logic rc_charge_enable,
	input wire logic [3:0] fine_bandwidth_code,
	input wire logic [11:0] fine_tune_select,
	input wire logic [10:0] fine_tune_ratio_milli,
	input wire logic otp_program_pulse,
	input wire logic [3:0] otp_program_index,
	input wire logic registers_ready
);
	int por_cnt, pulse_cnt, charge_cnt;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// counters, since these spans are too long for a repetition
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			por_cnt <= 0;
			pulse_cnt <= 0;
			charge_cnt <= 0;
		end else begin
			por_cnt <= registers_ready ? por_cnt : por_cnt + 1;
			pulse_cnt <= otp_program_pulse ? pulse_cnt + 1 : 0;
			charge_cnt <= rc_charge_enable ? charge_cnt + 1 : 0;
		end
	end
	sequence trip_hit;
		rc_charge_enable && rc_threshold_trip;
	endsequence
	sequence charge_drop;
		##[1:8] !rc_charge_enable;
	endsequence
	chk_ready_time: assert property (
		$rose(registers_ready) |-> por_cnt == POR_CYCLES)
		else $error("ready rose at the wrong cycle");
	chk_ready_holds: assert property (
		registers_ready |=> registers_ready)
		else $error("ready dropped without reset");
	chk_fine_onehot: assert property (
		fine_tune_select == (12'h001 << fine_bandwidth_code))
		else $error("fine select is not the decoded code");
	chk_fine_range: assert property (
		fine_bandwidth_code <= 4'hb)
		else $error("fine code above the last valid value");
	chk_ratio_track: assert property (
		registers_ready |-> fine_tune_ratio_milli ==
		filter_cal_pkg::FINE_RATIO_MILLI[$past(fine_bandwidth_code)])
		else $error("ratio does not follow the fine code");
	chk_pulse_length: assert property (
		$fell(otp_program_pulse) |-> pulse_cnt == OTP_PULSE_CYCLES)
		else $error("write pulse has the wrong length");
	chk_index_steady: assert property (
		otp_program_pulse && $past(otp_program_pulse)
		|-> $stable(otp_program_index))
		else $error("index moved during a write pulse");
	chk_charge_bound: assert property (
		charge_cnt <= CAL_TIMEOUT_CYCLES + 4)
		else $error("measurement ran past its time limit");
	chk_trip_ends: assert property (
		trip_hit |-> charge_drop)
		else $error("measurement kept going after the trip");
	chk_oe_between: assert property (
		$changed(serial_data_out_oe)
		|-> serial_port_select_b && $past(serial_port_select_b, 2))
		else $error("output enable moved inside a frame");
	chk_sdo_on_rise: assert property (
		!serial_port_select_b && serial_data_out_oe
		&& $changed(serial_data_out) |-> serial_clock)
		else $error("serial output moved while the clock was low");
endmodule
bind filter_cal_control filter_cal_control_properties #(
	.POR_CYCLES(POR_CYCLES),
	.CAL_TIMEOUT_CYCLES(CAL_TIMEOUT_CYCLES),
	.OTP_PULSE_CYCLES(OTP_PULSE_CYCLES)
) u_filter_cal_control_properties (
	.ref_clk(ref_clk),
	.rst_b(rst_b),
	.serial_port_select_b(serial_port_select_b),
	.serial_clock(serial_clock),
	.serial_data_out(serial_data_out),
	.serial_data_out_oe(serial_data_out_oe),
	.rc_threshold_trip(rc_threshold_trip),
	.rc_charge_enable(rc_charge_enable),
	.fine_bandwidth_code(fine_bandwidth_code),
	.fine_tune_select(fine_tune_select),
	.fine_tune_ratio_milli(fine_tune_ratio_milli),
	.otp_program_pulse(otp_program_pulse),
	.otp_program_index(otp_program_index),
	.registers_ready(registers_ready)
);

// file: verification/serial_host_model.sv
/*
 * Host side of the serial port: runs one whole 32-bit frame per call.
 * Assumes ref_clk paces it; the serial clock has a 125 ns period.
 */
`timescale 1ns/1ps
module serial_host_model (
	input wire logic ref_clk,
	input wire logic sdo,
	input wire logic sdo_oe,
	output logic sel_b,
	output logic sclk,
	output logic sdi,
	output logic done,
	output logic seen_oe,
	output logic [31:0] rx
);
	logic last;
	initial begin
		sel_b = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		done = 1'b0;
		seen_oe = 1'b0;
		rx = '0;
		last = 1'b0;
	end
	// a released output reads as the inverse of the last bit, so it
	// can never pass for real data
	task automatic xfer(input logic [31:0] w);
		@(negedge ref_clk);
		sel_b <= 1'b0;
		sdi <= w[31];
		seen_oe = 1'b1;
		for (int i = 31; i >= 0; i--) begin
			repeat (13) @(negedge ref_clk);
			sclk <= 1'b1;
			repeat (12) @(negedge ref_clk);
			sclk <= 1'b0;
			last = sdo_oe ? sdo : ~last;
			seen_oe = seen_oe & sdo_oe;
			rx[i] = last;
			if (i > 0) sdi <= w[i - 1];
		end
		repeat (6) @(negedge ref_clk);
		sel_b <= 1'b1;
		sdi <= ~sdi;
		done <= 1'b1;
		@(negedge ref_clk);
		done <= 1'b0;
		repeat (8) @(negedge ref_clk);
	endtask
endmodule

// file: verification/filter_cal_control_tb_top.sv
/*
 * Self-checking bench: register access, fine decode, calibration,
 * one-time memory, soft reset and chip address matching.
 * Assumes serial_host_model pulses done after every frame.
 */
`timescale 1ns/1ps
module filter_cal_control_tb_top;
	// arbitrary values, not tied to any real part
	localparam logic [2:0] ADR = 3'h6;
	localparam logic [23:0] ID = 24'h00_0abc;
	logic ref_clk, rst_b, sel_b, sclk, sdi, sdo, oe, cal_clk, trip;
	logic charge, dbl, use_set, pulse, ready, done, seen, live, cal_run;
	logic [3:0] coarse, fine, idx, c, k;
	logic [11:0] tsel;
	logic [10:0] ratio;
	logic [31:0] rx;
	logic [4:0] ptr;
	logic [32:0] note;
	logic [32:0] notes[$];
	int n_fail, n_tests, tcnt;
	filter_cal_control #(.POR_CYCLES(20), .CAL_TIMEOUT_CYCLES(4000),
		.OTP_PULSE_CYCLES(8), .DEVICE_BUS_ADDRESS(ADR),
		.DEVICE_ID(ID)) u_filter_cal_control (.ref_clk(ref_clk),
		.rst_b(rst_b), .serial_port_select_b(sel_b), .serial_clock(sclk),
		.serial_data_in(sdi), .serial_data_out(sdo),
		.serial_data_out_oe(oe), .calibration_clock_pin(cal_clk),
		.rc_threshold_trip(trip), .rc_charge_enable(charge),
		.clock_doubler_enable(dbl), .use_settings(use_set),
		.coarse_bandwidth_code(coarse), .fine_bandwidth_code(fine),
		.fine_tune_select(tsel), .fine_tune_ratio_milli(ratio),
		.otp_program_pulse(pulse), .otp_program_index(idx),
		.registers_ready(ready));
	serial_host_model u_serial_host_model (.ref_clk(ref_clk), .sdo(sdo),
		.sdo_oe(oe), .sel_b(sel_b), .sclk(sclk), .sdi(sdi),
		.done(done), .seen_oe(seen), .rx(rx));
	always #2.5 ref_clk = ~ref_clk;
	// 25 MHz, so the doubler is needed; it stands still between runs
	always #20 cal_clk = cal_run ? ~cal_clk : 1'b0;
	always @(negedge ref_clk) begin
		tcnt <= charge ? tcnt + 1 : 0;
		trip <= charge && tcnt > 3000;
	end
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [23:0] d,
		input logic [23:0] ed, input logic [2:0] ca);
		notes.push_back({live, ed, ptr, ADR});
		u_serial_host_model.xfer({d, a, ca});
		live = (ca == ADR);
		if (live && a == 5'h00) ptr = d[4:0];
	endtask
	task automatic w(input logic [4:0] a, input logic [23:0] d);
		wr(a, d, ID, ADR);
	endtask
	// the expectation is queued before the frame runs, since the
	// watcher takes the note off as soon as the frame ends
	task automatic rd(input logic [4:0] a, input logic [23:0] e);
		w(5'h00, {19'h0, a});
		wr(5'h00, 24'h00_0000, e, ADR);
	endtask
	task automatic close_out;
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	always @(posedge done) begin
		note = notes.pop_front();
		cmp(32'(seen), 32'(note[32]));
		if (note[32]) cmp(rx, note[31:0]);
	end
	initial begin
		repeat (75000) @(posedge ref_clk);
		n_fail++;
		close_out;
	end
	initial begin
		ref_clk = 1'b0;
		rst_b = 1'b0;
		cal_clk = 1'b0;
		trip = 1'b0;
		cal_run = 1'b0;
		live = 1'b0;
		ptr = 5'h00;
		tcnt = 0;
		void'($urandom(32'h8901_19d2));
		repeat (20) @(negedge ref_clk);
		rst_b = 1'b1;
		repeat (30) @(negedge ref_clk);
		cmp(32'(ready), 32'h1);
		w(5'h00, 24'h00_0000);
		rd(filter_cal_pkg::REG_CAL_CONTROL, 24'h00_0000);
		rd(filter_cal_pkg::REG_FINE_BW, 24'h00_0006);
		w(filter_cal_pkg::REG_CAL_CONTROL, 24'h00_0010);
		for (int i = 0; i < 3; i++) begin
			c = (i == 0) ? 4'h0 : (i == 1) ? 4'hb : 4'($urandom_range(11));
			k = 4'($urandom_range(8));
			w(filter_cal_pkg::REG_COARSE_BW, {14'h0, k, 6'h0});
			w(filter_cal_pkg::REG_FINE_BW, {20'h0, c});
			rd(filter_cal_pkg::REG_FINE_BW, {20'h0, c});
			cmp(32'(fine), 32'(c));
			cmp(32'(tsel), 32'(12'h001 << c));
			cmp(32'(ratio), 32'(filter_cal_pkg::FINE_RATIO_MILLI[c]));
			cmp(32'(coarse), 32'(k));
		end
		w(filter_cal_pkg::REG_CAL_PERIOD, 24'h00_7fff);
		w(filter_cal_pkg::REG_MEAS_ADJUST, 24'h00_0098);
		w(filter_cal_pkg::REG_CAL_CONTROL, 24'h00_0016);
		cmp(32'({dbl, use_set}), 32'h3);
		cal_run = 1'b1;
		w(filter_cal_pkg::REG_CAL_START, 24'h00_0000);
		rd(filter_cal_pkg::REG_STATUS, 24'h00_0016);
		for (int j = 0; j < 5000 && charge; j++) @(negedge ref_clk);
		cal_run = 1'b0;
		rd(filter_cal_pkg::REG_STATUS, 24'h00_000b);
		rd(filter_cal_pkg::REG_FINE_BW, 24'h00_000b);
		cmp(32'(fine), 32'hb);
		c = 4'($urandom_range(15, 3));
		w(filter_cal_pkg::REG_OTP_INDEX, 24'h00_0002);
		w(filter_cal_pkg::REG_OTP_STROBE, 24'h00_0000);
		w(filter_cal_pkg::REG_OTP_MODE, 24'h00_0001);
		w(filter_cal_pkg::REG_OTP_INDEX, {20'h0, c});
		w(filter_cal_pkg::REG_OTP_STROBE, 24'($urandom));
		cmp(32'(idx), 32'(c));
		w(filter_cal_pkg::REG_OTP_MODE, 24'h00_0000);
		rd(filter_cal_pkg::REG_STATUS, 24'h00_000b | (24'h40 << c));
		w(filter_cal_pkg::REG_READ_POINTER, 24'h00_0020);
		w(filter_cal_pkg::REG_READ_POINTER, 24'h00_0000);
		rd(filter_cal_pkg::REG_CAL_CONTROL, 24'h00_0000);
		rd(filter_cal_pkg::REG_FINE_BW, 24'h00_0006);
		rd(filter_cal_pkg::REG_STATUS, 24'h00_0006 | (24'h40 << c));
		cmp(32'({dbl, use_set}), 32'h0);
		wr(filter_cal_pkg::REG_FINE_BW, 24'h00_0001, ID, ~ADR);
		rd(filter_cal_pkg::REG_FINE_BW, 24'h00_0006);
		w(5'h07, 24'($urandom));
		rd(5'h07, 24'h00_0000);
		close_out;
	end
endmodule
